// ==== xog_pkg.sv ====
// Shared constants and types of the crystal oscillator start-up gate.
// Assumes a single 250 MHz mclk domain; all pad and control inputs are synchronous to it.
`default_nettype none

package xog_pkg;

	// Oscillator states
	typedef enum logic [1:0] {
		XOG_OFF,
		XOG_STARTUP,
		XOG_STABLE,
		XOG_EXTCLK
	} xog_state_t;

	// Start-up counter
	localparam int unsigned  STARTUP_W      = 13;
	localparam logic [12:0]  STARTUP_CYCLES = 13'h1000;   // Raw oscillator edges before release
	localparam logic [12:0]  CNT_RST        = 13'h0000;

	// Control settings: positions inside the load-capacitor field and reset values
	localparam int unsigned  CAP_W          = 4;
	localparam int unsigned  CAP_2P_BIT     = 3;
	localparam int unsigned  CAP_4P_BIT     = 2;
	localparam int unsigned  CAP_8P_BIT     = 1;
	localparam int unsigned  CAP_16P_BIT    = 0;
	localparam logic [3:0]   CAP_RST        = 4'h0;
	localparam logic         REF_EN_RST     = 1'h0;
	localparam logic         STOP_KEEP_RST  = 1'h0;

endpackage : xog_pkg

`default_nettype wire

// ==== xog_counter.sv ====
// Saturating start-up counter of raw oscillator edges.
// Assumes tick is a one-cycle pulse per raw oscillator rising edge seen in mclk.
`default_nettype none

module xog_counter (
	input  wire logic                          mclk,
	input  wire logic                          resetn,
	input  wire logic                          clear,
	input  wire logic                          tick,
	output logic [xog_pkg::STARTUP_W-1:0]      count,
	output logic                               done
);

	typedef struct packed {
		logic [xog_pkg::STARTUP_W-1:0] cnt;
		logic                          done;
	} xog_cnt_t;

	xog_cnt_t s_r;
	xog_cnt_t s_nxt;

	// Count up to the terminal value and hold there until cleared
	always_comb begin
		s_nxt = s_r;
		if (clear) begin
			s_nxt.cnt = xog_pkg::CNT_RST;                                   // RULE9
		end else if (tick && (s_r.cnt != xog_pkg::STARTUP_CYCLES)) begin
			s_nxt.cnt = s_r.cnt + 13'h0001;                                 // RULE3
		end
		s_nxt.done = (s_nxt.cnt == xog_pkg::STARTUP_CYCLES);             // RULE4 RULE18
	end

	// State register
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			s_r <= '0;
		end else begin
			s_r <= s_nxt;
		end
	end

	assign count = s_r.cnt;
	assign done  = s_r.done;

	// Checks on the counter
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!resetn);

	cnt_sat_a: assert property (s_r.done |-> s_r.cnt == xog_pkg::STARTUP_CYCLES) // RULE18
		else $error("Done without terminal count");
	done_cause_a: assert property ($rose(s_r.done) |-> $past(tick) && !$past(clear)) // RULE4
		else $error("Done rose without a counted edge");
	cnt_hold_a: assert property (s_r.done && !clear |=> s_r.done)        // RULE18
		else $error("Done dropped without clear");

endmodule : xog_counter

`default_nettype wire

// ==== xog_core.sv ====
// Crystal oscillator control: state walk, start-up gating, pad coupling, stop behaviour.
// Assumes raw_osc_clock and osc_input_pad are slow against mclk and synchronous to it.
//
// How it works
// RULE1 - With no clock needed, go off, raw clock static, minimal current; here the raw clock still follows the input pad when source select is 0.
// RULE2 - Off state decouples input pad and drive pad from oscillator logic.
// RULE3 - Enable with internal source enters startup; raw edges clock the counter.
// RULE4 - Output clock stays gated until 4096 raw cycles were counted.
// RULE5 - Enabled, internal source and count done means stable output clock.
// RULE6 - Enabled with internal source cleared buffers input pad onto output clock.
// RULE7 - Controller sets source select to 1 for crystal, 0 for pad clock.
// RULE8 - Oscillator mode uses both pads; external mode leaves drive pad free.
// RULE9 - No own reset state; counter clears whenever clocks are not generated.
// RULE10 - Never issue a reset request to the system.
// RULE11 - In stop, keep oscillating only if reference enable and stop keep set.
// RULE12 - Low leakage stop retains settings; functional if both bits set before.
// RULE13 - Waking from very low leakage stop clears all control bits.
// RULE14 - No interrupt is ever raised.
// RULE15 - Reference enable gates the external reference clock output.
// RULE16 - Reference clock runs in stop only if enabled before entry.
// RULE17 - Controller must not change range or power settings while running.
// RULE18 - Counter saturates; done and open gate persist until disabled.
// RULE19 - Output gate changes only while raw clock is low.
`default_nettype none

module xog_core (
	input  wire logic                       mclk,
	input  wire logic                       resetn,
	input  wire logic                       clocks_required,
	input  wire logic                       internal_source_select,
	input  wire logic                       raw_osc_clock,
	input  wire logic                       osc_input_pad,
	input  wire logic                       stop_mode,
	input  wire logic                       low_leak_stop,
	input  wire logic                       very_low_leak_wake,
	input  wire logic                       cfg_wr,
	input  wire logic                       cfg_ref_clock_enable,
	input  wire logic                       cfg_ref_clock_stop_keep,
	input  wire logic [xog_pkg::CAP_W-1:0]  cfg_cap_load,
	output logic                            osc_clk_out,
	output logic                            ext_ref_clock,
	output logic                            startup_count_done,
	output logic [1:0]                      osc_state,
	output logic                            input_pad_couple,
	output logic                            amp_enable,
	output logic                            osc_drive_pad_o,
	output logic                            osc_drive_pad_oe,
	output logic                            ref_clock_enable,
	output logic                            ref_clock_stop_keep,
	output logic [xog_pkg::CAP_W-1:0]       cap_load,
	output logic                            sys_reset_req
);

	typedef struct packed {
		xog_pkg::xog_state_t        st;
		logic                       raw_q;
		logic                       gate;
		logic                       clk_out;
		logic                       ext_ref;
		logic                       stop_q;
		logic                       keep_lat;
		logic                       rclk_en;
		logic                       stop_keep;
		logic [xog_pkg::CAP_W-1:0]  cap;
		logic                       in_couple;
		logic                       amp_en;
		logic                       drv_o;
		logic                       drv_oe;
		logic                       rst_req;
	} xog_core_t;

	xog_core_t s_r;
	xog_core_t s_nxt;

	logic                            any_stop;
	logic                            keep_now;
	logic                            gen_en;
	logic                            raw_sel;
	logic                            tick;
	logic                            cnt_clear;
	logic                            cnt_done;
	logic [xog_pkg::STARTUP_W-1:0]   cnt_val;

	// Keep-alive decision: taken from the live settings on the stop entry cycle,
	// so a kept oscillator never drops out for one cycle while the latch fills
	always_comb begin
		any_stop = stop_mode | low_leak_stop;
		if (any_stop && !s_r.stop_q) begin
			keep_now = s_r.rclk_en & s_r.stop_keep;                              // RULE16
		end else begin
			keep_now = s_r.keep_lat & any_stop;
		end
	end

	// Clock generation is wanted outside stop, or in stop when kept alive
	always_comb begin
		gen_en = clocks_required & (~any_stop | keep_now);                       // RULE11 RULE12
	end

	// Raw clock: amplifier output while running, pad clock when external, else static
	always_comb begin
		if (internal_source_select) begin
			raw_sel = s_r.amp_en & raw_osc_clock;                                // RULE1 RULE3
		end else begin
			raw_sel = osc_input_pad;                                             // RULE6
		end
		tick      = raw_sel & ~s_r.raw_q & s_r.amp_en;                          // RULE3
		cnt_clear = ~(gen_en & internal_source_select);                          // RULE9
	end

	// Start-up counter, counting raw edges
	xog_counter u_counter (
		.mclk   (mclk),
		.resetn (resetn),
		.clear  (cnt_clear),
		.tick   (tick),
		.count  (cnt_val),
		.done   (cnt_done)
	);

	// Next state of the whole block
	always_comb begin
		s_nxt        = s_r;
		s_nxt.raw_q  = raw_sel;
		s_nxt.stop_q = any_stop;

		// State walk
		if (!gen_en) begin
			s_nxt.st = xog_pkg::XOG_OFF;                                         // RULE1
		end else if (!internal_source_select) begin
			s_nxt.st = xog_pkg::XOG_EXTCLK;                                      // RULE6
		end else if (cnt_done) begin
			s_nxt.st = xog_pkg::XOG_STABLE;                                      // RULE5
		end else begin
			s_nxt.st = xog_pkg::XOG_STARTUP;                                     // RULE3
		end

		// Pad coupling per state
		case (s_nxt.st)
			xog_pkg::XOG_OFF: begin
				s_nxt.in_couple = 1'b0;                                          // RULE2
				s_nxt.amp_en    = 1'b0;                                          // RULE2
			end
			xog_pkg::XOG_STARTUP,
			xog_pkg::XOG_STABLE: begin
				s_nxt.in_couple = 1'b1;                                          // RULE8
				s_nxt.amp_en    = 1'b1;                                          // RULE8
			end
			xog_pkg::XOG_EXTCLK: begin
				s_nxt.in_couple = 1'b1;
				s_nxt.amp_en    = 1'b0;                                          // RULE8
			end
			default: begin
				s_nxt.in_couple = 1'b0;
				s_nxt.amp_en    = 1'b0;
			end
		endcase
		s_nxt.drv_oe = s_nxt.amp_en;                                             // RULE2 RULE8
		s_nxt.drv_o  = s_nxt.amp_en & ~osc_input_pad;                            // Inverting amplifier

		// Gate opens after the count or in external mode, and moves only on a low raw clock
		if (!raw_sel) begin
			s_nxt.gate = (s_nxt.st == xog_pkg::XOG_STABLE) ||
			             (s_nxt.st == xog_pkg::XOG_EXTCLK);                     // RULE4 RULE19
		end
		s_nxt.clk_out = raw_sel & s_r.gate;                                      // RULE4 RULE18

		// Stop keep-alive is held from stop entry and dropped when stop ends
		s_nxt.keep_lat = keep_now;                                               // RULE16
		s_nxt.ext_ref  = raw_sel & s_r.gate & s_r.rclk_en &
		                 (~any_stop | keep_now);                                 // RULE15 RULE16

		// Control settings: cleared on deep wake, held through low leakage stop
		if (very_low_leak_wake) begin
			s_nxt.rclk_en   = xog_pkg::REF_EN_RST;                               // RULE13
			s_nxt.stop_keep = xog_pkg::STOP_KEEP_RST;                            // RULE13
			s_nxt.cap       = xog_pkg::CAP_RST;                                  // RULE13
		end else if (cfg_wr && !low_leak_stop) begin
			s_nxt.rclk_en   = cfg_ref_clock_enable;                              // RULE12
			s_nxt.stop_keep = cfg_ref_clock_stop_keep;
			s_nxt.cap       = cfg_cap_load;
		end

		// No reset request and no interrupt exist in this block
		s_nxt.rst_req = 1'b0;                                                    // RULE10 RULE14
	end

	// State register
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			s_r           <= '0;
			s_r.st        <= xog_pkg::XOG_OFF;
			s_r.rclk_en   <= xog_pkg::REF_EN_RST;
			s_r.stop_keep <= xog_pkg::STOP_KEEP_RST;
			s_r.cap       <= xog_pkg::CAP_RST;
		end else begin
			s_r <= s_nxt;
		end
	end

	// Outputs straight from the state register, done straight from the counter register
	assign osc_clk_out         = s_r.clk_out;
	assign ext_ref_clock       = s_r.ext_ref;
	assign startup_count_done  = cnt_done;
	assign osc_state           = s_r.st;
	assign input_pad_couple    = s_r.in_couple;
	assign amp_enable          = s_r.amp_en;
	assign osc_drive_pad_o     = s_r.drv_o;
	assign osc_drive_pad_oe    = s_r.drv_oe;
	assign ref_clock_enable    = s_r.rclk_en;
	assign ref_clock_stop_keep = s_r.stop_keep;
	assign cap_load            = s_r.cap;
	assign sys_reset_req       = s_r.rst_req;

	// Checks on the block, all sampled on mclk and silent during reset
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!resetn);

	// State walk and pad coupling follow enable, source select and the count
	startup_map_a: assert property (                                              // RULE3
		gen_en && internal_source_select && !cnt_done
		|=> s_r.st == xog_pkg::XOG_STARTUP && s_r.amp_en && s_r.drv_oe)
		else $error("Startup state not entered");
	stable_map_a: assert property (                                               // RULE5
		gen_en && internal_source_select && cnt_done
		|=> s_r.st == xog_pkg::XOG_STABLE)
		else $error("Stable state not entered");
	ext_map_a: assert property (                                                  // RULE6
		gen_en && !internal_source_select
		|=> s_r.st == xog_pkg::XOG_EXTCLK && !s_r.drv_oe && s_r.in_couple)
		else $error("External clock state wrong");
	off_pads_a: assert property (                                                 // RULE1 RULE2
		!gen_en
		|=> s_r.st == xog_pkg::XOG_OFF && !s_r.in_couple && !s_r.amp_en && !s_r.drv_oe)
		else $error("Off state keeps pads coupled");
	raw_static_a: assert property (                                               // RULE1
		s_r.st == xog_pkg::XOG_OFF && internal_source_select |-> !raw_sel)
		else $error("Raw clock moves while off");
	drive_free_a: assert property (s_r.st == xog_pkg::XOG_EXTCLK |-> !s_r.drv_oe) // RULE8
		else $error("Drive pad used in external mode");
	no_reset_a: assert property (!s_r.rst_req)                               // RULE10
		else $error("Reset request raised");

	// Counter clearing and the release of the output gate
	cnt_clear_a: assert property (!(gen_en && internal_source_select) |=> !cnt_done) // RULE9
		else $error("Counter not cleared when disabled");
	gate_count_a: assert property (                                               // RULE4
		$rose(s_r.gate) && $past(internal_source_select)
		|-> $past(cnt_val) == xog_pkg::STARTUP_CYCLES)
		else $error("Gate opened before the full count");
	gated_start_a: assert property (                                              // RULE4
		s_r.st == xog_pkg::XOG_STARTUP [*2]
		|-> !s_r.gate || $past(s_r.st) != xog_pkg::XOG_STARTUP)
		else $error("Output open during startup");
	gate_hold_a: assert property (                                                // RULE18
		s_r.st == xog_pkg::XOG_STABLE && s_r.gate && gen_en && internal_source_select
		|=> s_r.gate)
		else $error("Gate closed while still stable");
	gate_low_a: assert property ($changed(s_r.gate) |-> !$past(raw_sel))      // RULE19
		else $error("Gate changed while raw clock high");
	stable_pass_a: assert property (                                              // RULE5
		s_r.st == xog_pkg::XOG_STABLE && s_r.gate && internal_source_select
		|=> s_r.clk_out == $past(raw_sel))
		else $error("Stable clock not passed to output");
	ext_pass_a: assert property (                                                 // RULE6
		s_r.st == xog_pkg::XOG_EXTCLK && s_r.gate && !internal_source_select
		|=> s_r.clk_out == $past(osc_input_pad))
		else $error("Pad clock not passed to output");

	// Reference clock and stop keep-alive
	ref_gate_a: assert property (s_r.ext_ref |-> $past(s_r.rclk_en))          // RULE15
		else $error("Reference clock without enable");
	stop_off_a: assert property (                                                 // RULE11
		any_stop && !s_r.keep_lat && s_r.stop_q
		|=> s_r.st == xog_pkg::XOG_OFF)
		else $error("Oscillator ran in stop without keep");
	stop_keep_a: assert property (                                                // RULE11
		any_stop && !s_r.stop_q && clocks_required && s_r.rclk_en && s_r.stop_keep
		|=> s_r.st != xog_pkg::XOG_OFF)
		else $error("Kept oscillator dropped at stop entry");
	keep_latch_a: assert property (                                               // RULE16
		any_stop && !s_r.stop_q
		|=> s_r.keep_lat == ($past(s_r.rclk_en) && $past(s_r.stop_keep)))
		else $error("Keep-alive not taken at stop entry");

	// Control settings through low leakage stop and deep wake
	leak_hold_a: assert property (                                                // RULE12
		low_leak_stop && !very_low_leak_wake
		|=> $stable(s_r.rclk_en) && $stable(s_r.stop_keep) && $stable(s_r.cap))
		else $error("Settings changed in low leakage stop");
	deep_wake_a: assert property (                                                // RULE13
		very_low_leak_wake
		|=> !s_r.rclk_en && !s_r.stop_keep && s_r.cap == xog_pkg::CAP_RST)
		else $error("Controls kept after deep wake");

	// Main scenarios
	reach_stable_c: cover property (s_r.st == xog_pkg::XOG_STARTUP ##1
		s_r.st == xog_pkg::XOG_STABLE);
	reach_ext_c: cover property (s_r.st == xog_pkg::XOG_EXTCLK && s_r.clk_out);
	stop_keep_c: cover property (any_stop && s_r.keep_lat && s_r.ext_ref);
	leak_cfg_c: cover property (low_leak_stop && cfg_wr);
	deep_wake_c: cover property (very_low_leak_wake && s_r.rclk_en);

endmodule : xog_core

`default_nettype wire

// ==== xog_osc_drive_pad_model.sv ====
// Behavioural crystal and pad clock source for the oscillator gate bench.
// Assumes mclk is the bench clock; outputs change just after its rising edge.
`default_nettype none

module xog_osc_drive_pad_model (
	input  wire logic mclk,
	input  wire logic amp_on,
	input  wire logic ext_run,
	output var logic  raw_clk,
	output var logic  pad_clk
);
	timeunit 1ns;
	timeprecision 1ps;

	logic [1:0] div_r;

	initial begin
		div_r = 2'h0;
		raw_clk = 1'h0;
		pad_clk = 1'h0;
	end

	// Four mclk cycles per period, each level held two cycles
	always @(posedge mclk) begin
		div_r   <= div_r + 2'h1;
		raw_clk <= amp_on & div_r[1];
		pad_clk <= ext_run & div_r[1];
	end

endmodule : xog_osc_drive_pad_model

`default_nettype wire

// ==== crystal_osc_startup_gate_test.sv ====
// Self-checking bench of the oscillator control core with a crystal model.
// Assumes one 250 MHz clock; the bench plays the controlling logic.
`default_nettype none

module crystal_osc_startup_gate_test;
	timeunit 1ns;
	timeprecision 1ps;

	logic        mclk, resetn, en, sel, raw, pad, stop, leak_stop, wake, ext_run;
	logic        cfg_wr, cfg_ref, cfg_keep, clk_out, ref_clk, done, couple, amp;
	logic        dr_o, dr_oe, ref_en, keep, rst_req;
	logic [3:0]  cfg_cap, cap;
	logic [1:0]  state;
	logic [15:0] rises;
	logic        raw_q;
	logic [5:0]  rows [4];
	int          failures, num_checks, early;

	xog_core u_dut (
		.mclk(mclk), .resetn(resetn), .clocks_required(en), .internal_source_select(sel),
		.raw_osc_clock(raw), .osc_input_pad(pad), .stop_mode(stop), .low_leak_stop(leak_stop),
		.very_low_leak_wake(wake), .cfg_wr(cfg_wr), .cfg_ref_clock_enable(cfg_ref),
		.cfg_ref_clock_stop_keep(cfg_keep), .cfg_cap_load(cfg_cap), .osc_clk_out(clk_out),
		.ext_ref_clock(ref_clk), .startup_count_done(done), .osc_state(state),
		.input_pad_couple(couple), .amp_enable(amp), .osc_drive_pad_o(dr_o),
		.osc_drive_pad_oe(dr_oe), .ref_clock_enable(ref_en), .ref_clock_stop_keep(keep),
		.cap_load(cap), .sys_reset_req(rst_req)
	);

	xog_osc_drive_pad_model u_crystal (
		.mclk(mclk), .amp_on(amp), .ext_run(ext_run), .raw_clk(raw), .pad_clk(pad)
	);

	initial begin
		mclk = 1'h0;
		forever #2 mclk = ~mclk;
	end

	// Count raw rising edges that the core can see while its amplifier runs
	always @(posedge mclk) begin
		raw_q <= raw;
		if (!en)
			rises <= 16'h0000;
		else if (amp && raw && !raw_q)
			rises <= rises + 16'h0001;
	end

	task check(input string what, input logic [15:0] seen, input logic [15:0] exp);
		num_checks++;
		if (seen !== exp) begin
			failures++;
			$display("BAD %s exp %h seen %h", what, exp, seen);
		end
	endtask : check

	task end_sim;
		$display("checks %0d failures %0d", num_checks, failures);
		if (failures == 0 && num_checks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask : end_sim

	task look;
		@(negedge mclk);
	endtask : look

	// Bounded wait for an output to go high: 0 done, 1 output clock, 2 reference clock
	task wait_for(input int which, input int lim, input string what);
		logic v;
		v = 1'h0;
		repeat (lim) begin
			look();
			v = (which == 0) ? done : (which == 1) ? clk_out : ref_clk;
			if (which == 0 && clk_out === 1'b1)
				early++;
			if (v === 1'b1)
				break;
		end
		check(what, v, 16'h0001);
		if (v !== 1'b1)
			end_sim();
	endtask : wait_for

	initial begin
		{en, sel, stop, leak_stop, wake, ext_run, cfg_wr, cfg_ref, cfg_keep} = 9'h000;
		cfg_cap = 4'h0;
		resetn = 1'h0;
		raw_q = 1'h0;
		rises = 16'h0000;
		// Enable, select, expected state, drive enable, amplifier
		rows[0] = {2'b00, xog_pkg::XOG_OFF, 2'b00};
		rows[1] = {2'b01, xog_pkg::XOG_OFF, 2'b00};
		rows[2] = {2'b10, xog_pkg::XOG_EXTCLK, 2'b00};
		rows[3] = {2'b11, xog_pkg::XOG_STARTUP, 2'b11};
		repeat (3) @(posedge mclk);
		resetn <= 1'h1;
		look();
		check("reset state", state, xog_pkg::XOG_OFF);
		check("reset req", rst_req, 16'h0000);
		check("reset ref en", ref_en, xog_pkg::REF_EN_RST);
		check("reset cap", cap, xog_pkg::CAP_RST);
		for (int i = 0; i < 4; i++) begin
			@(posedge mclk);
			{en, sel} <= rows[i][5:4];
			@(posedge mclk);
			look();
			check("state", state, rows[i][3:2]);
			check("drive oe", dr_oe, rows[i][1]);
			check("amp", amp, rows[i][0]);
			check("couple", couple, rows[i][5]);
			check("drive out", dr_o, rows[i][0]);
		end
		early = 0;
		wait_for(0, 20000, "done");
		check("raw count", rises, {3'h0, xog_pkg::STARTUP_CYCLES});
		check("early clock", 16'(early), 16'h0000);
		wait_for(1, 12, "stable clock");
		check("stable", state, xog_pkg::XOG_STABLE);
		repeat (50) look();
		check("done holds", done, 16'h0001);
		check("stable holds", state, xog_pkg::XOG_STABLE);
		@(posedge mclk);
		en <= 1'h0;
		repeat (3) look();
		check("done cleared", done, 16'h0000);
		check("off", state, xog_pkg::XOG_OFF);
		check("off clock", clk_out, 16'h0000);
		@(posedge mclk);
		{en, sel, ext_run, cfg_wr, cfg_ref, cfg_keep} <= 6'b101111;
		cfg_cap <= 4'hA;
		@(posedge mclk);
		cfg_wr <= 1'h0;
		wait_for(1, 12, "pad clock");
		check("ref en", ref_en, 16'h0001);
		check("keep", keep, 16'h0001);
		check("cap", cap, 16'h000A);
		wait_for(2, 12, "ref clock");
		@(posedge mclk);
		stop <= 1'h1;
		repeat (3) look();
		check("stop kept", state, xog_pkg::XOG_EXTCLK);
		wait_for(2, 12, "stop ref clock");
		@(posedge mclk);
		{leak_stop, cfg_wr, cfg_ref, cfg_keep} <= 4'b1100;
		cfg_cap <= 4'h0;
		@(posedge mclk);
		cfg_wr <= 1'h0;
		repeat (2) look();
		check("leak ref en", ref_en, 16'h0001);
		check("leak cap", cap, 16'h000A);
		check("leak state", state, xog_pkg::XOG_EXTCLK);
		@(posedge mclk);
		{leak_stop, stop, wake} <= 3'b001;
		@(posedge mclk);
		wake <= 1'h0;
		look();
		check("wake ref en", ref_en, 16'h0000);
		check("wake keep", keep, 16'h0000);
		check("wake cap", cap, 16'h0000);
		repeat (8) begin
			look();
			check("ref clock off", ref_clk, 16'h0000);
		end
		@(posedge mclk);
		stop <= 1'h1;
		repeat (2) look();
		check("stop off", state, xog_pkg::XOG_OFF);
		@(posedge mclk);
		{stop, resetn} <= 2'b00;
		repeat (2) look();
		check("mid reset", state, xog_pkg::XOG_OFF);
		check("mid reset req", rst_req, 16'h0000);
		@(posedge mclk);
		resetn <= 1'h1;
		repeat (2) look();
		check("after reset", state, xog_pkg::XOG_EXTCLK);
		check("after reset ref", ref_en, xog_pkg::REF_EN_RST);
		check("after reset req", rst_req, 16'h0000);
		end_sim();
	end

endmodule : crystal_osc_startup_gate_test

`default_nettype wire
